// >>> common/sfm_pkg.sv
// Constants, types and decode helpers of the serial flash mode front end.
// How it works
// - Quad output and quad I/O opcodes need quad enable; lanes two and three turn bidirectional.
// - Opcode 38h enters four-wire command mode, FFh leaves it; one mode at a time.
// - Opcode takes two clocks on four lanes, or eight clocks on serial input.
// - Power-up and software reset leave the serial mode selected.
// - Four-wire command mode needs quad enable set before the switch.
// - Double-edge reads take the opcode on rising edges, then use both edges.
// - Pause exists only with quad enable clear; otherwise the pin is lane three.
// - Pause starts at pin fall if clock is low, else after next clock fall.
// - Pause ends at pin rise if clock is low, else after next clock fall.
// - While paused, output floats and clock and serial input are ignored.
// - Enable-reset then reset opcode resets; about 30us with no commands.
// - Select bit makes the shared pin pause (0) or active-low reset (1).
// - Reset low about 1us restores power-on state; aborts operations; blocks commands.
// - With quad enable set the shared pin is only a data lane.
// - Dedicated reset pin works regardless of select and quad enable bits.
// - Hardware reset overrides every other input and interrupts any operation.
// - Low supply holds reset; then write-class opcodes stay blocked for a delay.
// - Write latch clears at power-up and completion; write enable must precede writes.
// - After power-down only release-from-power-down is accepted.
// - Lock bit per block and edge sector; all set at power-on; 39h clears.
// - Scheme select chooses range protection (0) or individual locks (1).
// - Serial clock may idle low or high at chip select edges.
// - During busy only status reads and suspend are accepted.
// - Enter four-wire opcode is ignored while quad enable is clear.
`default_nettype none
package sfm_pkg;
	localparam logic [7:0] OP_ENTER_4W = 8'h38;
	localparam logic [7:0] OP_EXIT_4W = 8'hFF;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_PDOWN = 8'hB9;
	localparam logic [7:0] OP_PREL = 8'hAB;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_RDSR3 = 8'h15;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0B;
	localparam logic [7:0] OP_DREAD_O = 8'h3B;
	localparam logic [7:0] OP_DREAD_IO = 8'hBB;
	localparam logic [7:0] OP_QREAD_O = 8'h6B;
	localparam logic [7:0] OP_QREAD_IO = 8'hEB;
	localparam logic [7:0] OP_DTR_READ = 8'h0D;
	localparam logic [7:0] OP_DTR_DREAD = 8'hBD;
	localparam logic [7:0] OP_DTR_QREAD = 8'hED;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_QPROG = 8'h32;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_CE1 = 8'hC7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam logic [7:0] OP_WRSR1 = 8'h01;
	localparam logic [7:0] OP_WRSR2 = 8'h31;
	localparam logic [7:0] OP_WRSR3 = 8'h11;
	localparam int CLK_PERIOD_NS = 25;
	localparam int RESET_PULSE_NS = 1000;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SW_RESET_NS = 30000;
	localparam int SW_RESET_CYC = SW_RESET_NS / CLK_PERIOD_NS;
	localparam logic [4:0] OP_BITS = 5'h08;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [4:0] DATA_BITS = 5'h08;
	localparam int LOCK_N = 286;
	localparam logic [8:0] TOP_SECT_BASE = 9'h010;
	localparam logic [8:0] MID_BLOCK_BASE = 9'h01F;
	localparam logic LOCK_RESET = 1'b1;
	localparam logic [7:0] SYNC_RESET = 8'h5F;
	typedef enum logic [1:0] {
		PH_OP = 2'b00,
		PH_ADDR = 2'b01,
		PH_DATA = 2'b10,
		PH_IGNORE = 2'b11
	} sfm_phase_t;
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic dtr;
	} sfm_cmd_t;
	typedef struct packed {
		logic quad_enable_bit;
		logic pause_or_reset_select;
		logic protect_scheme_select;
	} sfm_cfg_t;
	typedef struct packed {
		logic four_wire_command_mode;
		logic write_latch_flag;
		logic paused;
		logic power_down;
		logic reset_busy;
		logic write_lockout;
	} sfm_stat_t;
	function automatic logic is_dtr(input logic [7:0] op);
		return op == OP_DTR_READ || op == OP_DTR_DREAD || op == OP_DTR_QREAD;
	endfunction
	function automatic logic is_read(input logic [7:0] op);
		return is_dtr(op) || op == OP_READ || op == OP_FREAD || op == OP_DREAD_O
			|| op == OP_DREAD_IO || op == OP_QREAD_O || op == OP_QREAD_IO;
	endfunction
	function automatic logic is_write(input logic [7:0] op);
		return op == OP_PROG || op == OP_QPROG || op == OP_SE || op == OP_BE32 || op == OP_BE64
			|| op == OP_CE1 || op == OP_CE2 || op == OP_WRSR1 || op == OP_WRSR2 || op == OP_WRSR3;
	endfunction
	function automatic logic is_addr(input logic [7:0] op);
		return is_read(op) || op == OP_UNLOCK || op == OP_PROG || op == OP_QPROG
			|| op == OP_SE || op == OP_BE32 || op == OP_BE64;
	endfunction
	function automatic logic is_quad(input logic [7:0] op);
		return op == OP_QREAD_O || op == OP_QREAD_IO || op == OP_QPROG || op == OP_DTR_QREAD;
	endfunction
	function automatic logic [2:0] addr_lanes(input logic [7:0] op, input logic fw);
		if (fw || op == OP_QREAD_IO || op == OP_DTR_QREAD) return 3'h4;
		if (op == OP_DREAD_IO || op == OP_DTR_DREAD) return 3'h2;
		return 3'h1;
	endfunction
	function automatic logic [2:0] out_lanes(input logic [7:0] op, input logic fw);
		if (fw || op == OP_QREAD_O || op == OP_QREAD_IO || op == OP_DTR_QREAD) return 3'h4;
		if (op == OP_DREAD_O || op == OP_DREAD_IO || op == OP_DTR_DREAD) return 3'h2;
		return 3'h1;
	endfunction
	function automatic logic [23:0] shift_in(input logic [23:0] a, input logic [3:0] io, input logic [2:0] n);
		if (n == 3'h4) return {a[19:0], io};
		if (n == 3'h2) return {a[21:0], io[1:0]};
		return {a[22:0], io[0]};
	endfunction
	function automatic logic [8:0] lock_index(input logic [23:0] a);
		if (a[23:16] == 8'h00) return {5'h00, a[15:12]};
		if (a[23:16] == 8'hFF) return TOP_SECT_BASE + {5'h00, a[15:12]};
		return MID_BLOCK_BASE + {1'b0, a[23:16]};
	endfunction
endpackage
`default_nettype wire

// >>> verilog/sfm_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
`default_nettype none
module sfm_sync
	import sfm_pkg::*;
#(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				meta[i] <= RST_VAL[i];
				dout[i] <= RST_VAL[i];
			end else begin
				meta[i] <= din[i];
				dout[i] <= meta[i];
			end
		end
	end
endmodule
`default_nettype wire

// >>> verilog/sfm_front.sv
// Mode, pause, reset and write protection front end of the serial flash.
`default_nettype none
module sfm_front
	import sfm_pkg::*;
#(
	parameter bit HAS_RESET_PIN = 1'b1,
	parameter int PUW_CYCLES = 4000
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sck,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_b,
	input wire logic reset_pin_b,
	input wire logic supply_ok,
	input wire sfm_cfg_t cfg,
	input wire logic busy,
	input wire logic op_done,
	input wire logic range_hit,
	input wire logic [7:0] rd_data,
	output var logic rd_next,
	output logic [23:0] prot_addr,
	output var sfm_cmd_t cmd,
	output logic abort,
	output sfm_stat_t stat
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Synchronised pins and edges
	// ----------------------------------------
	logic [7:0] sync_q;
	logic [3:0] io_s;
	logic cs_s;
	logic sck_s;
	logic rpin_s;
	logic pwr_s;
	logic sck_d;
	logic sck_rise;
	logic sck_fall;

	sfm_sync #(.W(8), .RST_VAL(SYNC_RESET)) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.din({supply_ok, reset_pin_b, sck, cs_b, io_in}),
		.dout(sync_q)
	);

	assign io_s = sync_q[3:0];
	assign cs_s = sync_q[4];
	assign sck_s = sync_q[5];
	assign rpin_s = sync_q[6];
	assign pwr_s = sync_q[7];
	assign sck_rise = sck_s && !sck_d;
	assign sck_fall = !sck_s && sck_d;

	// ----------------------------------------
	// State
	// ----------------------------------------
	sfm_phase_t phase;
	logic [4:0] cnt;
	logic [7:0] op;
	logic [23:0] addr;
	logic [7:0] dout;
	logic data_on;
	logic four_wire;
	logic wl;
	logic pdown;
	logic armed;
	logic paused;
	logic [5:0] hw_cnt;
	logic [10:0] sw_cnt;
	logic [15:0] puw_cnt;
	logic [LOCK_N-1:0] locks;

	// ----------------------------------------
	// Reset and pause decode
	// ----------------------------------------
	logic qe;
	logic hw_low;
	logic hw_fire;
	logic sw_fire;
	logic sw_busy;
	logic apply_rst;
	logic halt;
	logic puw_active;
	logic pause_allowed;
	logic live;

	assign qe = cfg.quad_enable_bit;
	assign hw_low = (HAS_RESET_PIN && !rpin_s)
		|| (!qe && cfg.pause_or_reset_select && !io_s[3]);
	assign hw_fire = hw_cnt == 6'(RESET_PULSE_CYC);
	assign sw_busy = sw_cnt != 11'h000;
	assign apply_rst = !pwr_s || hw_fire || sw_fire;
	assign halt = hw_low || sw_busy || !pwr_s;
	assign puw_active = pwr_s && puw_cnt != 16'(PUW_CYCLES);
	assign pause_allowed = !qe && !cfg.pause_or_reset_select;
	assign live = !cs_s && !paused && !halt;
	assign abort = apply_rst;

	// ----------------------------------------
	// Opcode capture and acceptance
	// ----------------------------------------
	logic [4:0] op_step;
	logic [7:0] next_op;
	logic op_edge;
	logic op_end;
	logic op_ok;
	logic op_take;

	assign op_step = four_wire ? 5'h04 : 5'h01;
	assign next_op = four_wire ? {op[3:0], io_s} : {op[6:0], io_s[0]};
	assign op_edge = live && phase == PH_OP && sck_rise;
	assign op_end = op_edge && 5'(cnt + op_step) == OP_BITS;
	assign op_ok = (!pdown || next_op == OP_PREL)
		&& (!busy || next_op == OP_RDSR1 || next_op == OP_RDSR2
		|| next_op == OP_RDSR3 || next_op == OP_SUSPEND)
		&& (!is_quad(next_op) || qe)
		&& (!is_write(next_op) || (wl && !puw_active))
		&& (next_op != OP_WREN || !puw_active)
		&& (next_op != OP_ENTER_4W || qe);
	assign op_take = op_end && op_ok;
	assign sw_fire = op_take && next_op == OP_RST && armed;

	// ----------------------------------------
	// Address, protection and data out
	// ----------------------------------------
	logic dtr;
	logic [2:0] alanes;
	logic [2:0] olanes;
	logic [23:0] next_addr;
	logic addr_edge;
	logic addr_end;
	logic [8:0] lidx;
	logic blocked;
	logic out_edge;
	logic byte_end;
	logic issue;
	logic drive;
	logic [3:0] lane_mask;

	assign dtr = is_dtr(op);
	assign alanes = addr_lanes(op, four_wire);
	assign olanes = out_lanes(op, four_wire);
	assign next_addr = shift_in(addr, io_s, alanes);
	assign addr_edge = live && phase == PH_ADDR && (sck_rise || (dtr && sck_fall));
	assign addr_end = addr_edge && 5'(cnt + {2'b00, alanes}) == ADDR_BITS;
	assign prot_addr = next_addr;
	assign lidx = lock_index(next_addr);
	assign blocked = cfg.protect_scheme_select ? locks[lidx] : range_hit;
	assign out_edge = live && phase == PH_DATA && (sck_fall || (dtr && sck_rise));
	assign byte_end = out_edge && data_on && 5'(cnt + {2'b00, olanes}) == DATA_BITS;
	assign issue = (op_take && !is_addr(next_op)) || (addr_end && !(is_write(op) && blocked));
	assign drive = phase == PH_DATA && data_on && !cs_s && !paused;
	assign lane_mask = olanes == 3'h4 ? 4'h0 : (olanes == 3'h2 ? 4'hC : 4'hD);
	assign io_oe_b = drive ? lane_mask : 4'hF;
	assign io_out = olanes == 3'h4 ? dout[7:4] : {2'b00, dout[7], olanes == 3'h2 && dout[6]};
	assign stat = '{four_wire_command_mode: four_wire, write_latch_flag: wl, paused: paused,
		power_down: pdown, reset_busy: halt, write_lockout: puw_active};

	// ----------------------------------------
	// Frame sequencing
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= PH_OP;
			cnt <= 5'h00;
			op <= 8'h00;
			data_on <= 1'b0;
		end else if (apply_rst || cs_s) begin
			phase <= PH_OP;
			cnt <= 5'h00;
			data_on <= 1'b0;
		end else if (op_end) begin
			op <= next_op;
			cnt <= 5'h00;
			phase <= (op_take && is_addr(next_op)) ? PH_ADDR : PH_IGNORE;
		end else if (op_edge) begin
			op <= next_op;
			cnt <= 5'(cnt + op_step);
		end else if (addr_end) begin
			cnt <= 5'h00;
			phase <= is_read(op) ? PH_DATA : PH_IGNORE;
		end else if (addr_edge) begin
			cnt <= 5'(cnt + {2'b00, alanes});
		end else if (out_edge) begin
			data_on <= 1'b1;
			cnt <= (byte_end || !data_on) ? 5'h00 : 5'(cnt + {2'b00, olanes});
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sck_d <= 1'b0;
			addr <= 24'h000000;
		end else begin
			sck_d <= sck_s;
			addr <= addr_edge ? next_addr : addr;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dout <= 8'h00;
			rd_next <= 1'b0;
		end else begin
			rd_next <= (addr_end && is_read(op)) || byte_end;
			if ((addr_end && is_read(op)) || byte_end) begin
				dout <= rd_data;
			end else if (out_edge && data_on) begin
				dout <= 8'(dout << olanes);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd <= '0;
		end else begin
			cmd.valid <= issue;
			cmd.opcode <= addr_end ? op : next_op;
			cmd.addr <= addr_end ? next_addr : 24'h000000;
			cmd.dtr <= addr_end && dtr;
		end
	end

	// ----------------------------------------
	// Mode, latch and power-down flags
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			four_wire <= 1'b0;
			pdown <= 1'b0;
			armed <= 1'b0;
		end else if (apply_rst) begin
			four_wire <= 1'b0;
			pdown <= 1'b0;
			armed <= 1'b0;
		end else if (op_take) begin
			four_wire <= next_op == OP_ENTER_4W || (four_wire && next_op != OP_EXIT_4W);
			pdown <= next_op == OP_PDOWN;
			armed <= next_op == OP_RST_EN;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wl <= 1'b0;
		end else if (apply_rst) begin
			wl <= 1'b0;
		end else if (op_take && next_op == OP_WREN) begin
			wl <= 1'b1;
		end else if (op_done || (op_take && next_op == OP_WRDI)) begin
			wl <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			paused <= 1'b0;
		end else if (cs_s || !pause_allowed || halt) begin
			paused <= 1'b0;
		end else if (!sck_s) begin
			paused <= !io_s[3];
		end
	end

	// ----------------------------------------
	// Reset timers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hw_cnt <= 6'h00;
			sw_cnt <= 11'h000;
			puw_cnt <= 16'h0000;
		end else begin
			hw_cnt <= !hw_low ? 6'h00 : (hw_fire ? hw_cnt : 6'(hw_cnt + 6'h01));
			sw_cnt <= sw_fire ? 11'(SW_RESET_CYC) : (sw_busy ? 11'(sw_cnt - 11'h001) : sw_cnt);
			puw_cnt <= !pwr_s ? 16'h0000 : (puw_active ? 16'(puw_cnt + 16'h0001) : puw_cnt);
		end
	end

	// ----------------------------------------
	// Individual locks
	// ----------------------------------------
	for (genvar i = 0; i < LOCK_N; i++) begin : g_lock
		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				locks[i] <= LOCK_RESET;
			end else if (apply_rst) begin
				locks[i] <= LOCK_RESET;
			end else if (addr_end && op == OP_UNLOCK && lidx == 9'(i)) begin
				locks[i] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_QUAD_QE: assert property (op_end && is_quad(next_op) && !qe |=> phase == PH_IGNORE)
		else $error("Quad opcode taken without quad enable.");
	AST_ENTER_4W: assert property (op_take && next_op == OP_ENTER_4W |=> four_wire [*2])
		else $error("Four-wire mode not entered.");
	AST_4W_NEEDS_QE: assert property (op_end && next_op == OP_ENTER_4W && !qe |=> !$rose(four_wire))
		else $error("Four-wire mode entered without quad enable.");
	AST_OP_CLOCKS: assert property (op_end |-> cnt == (four_wire ? 5'h04 : 5'h07))
		else $error("Opcode length wrong.");
	AST_SW_RESET: assert property (sw_fire |=> !four_wire && !wl && halt [*8])
		else $error("Software reset did not reset.");
	AST_PAUSE_QE: assert property (qe && $past(qe) |-> !paused)
		else $error("Pause active with quad enable.");
	AST_PAUSE_START: assert property (live && pause_allowed && !io_s[3] && !sck_s |=> paused || cs_s || halt)
		else $error("Pause did not start.");
	AST_PAUSE_END: assert property (paused && io_s[3] && !sck_s |=> !paused)
		else $error("Pause did not end.");
	AST_PAUSE_FLOAT: assert property (paused |-> io_oe_b == 4'hF && !op_edge && !out_edge)
		else $error("Activity during pause.");
	AST_HW_RESET: assert property ($rose(hw_fire) |=> !four_wire && !wl && &locks)
		else $error("Hardware reset did not restore state.");
	AST_HW_BLOCK: assert property (hw_low |-> !op_take)
		else $error("Command taken in reset.");
	AST_PUW: assert property (puw_active && op_end && (is_write(next_op) || next_op == OP_WREN) |-> !op_take)
		else $error("Write taken during power-up delay.");
	AST_WL_DONE: assert property (op_done && !(op_take && next_op == OP_WREN) |=> !wl)
		else $error("Write latch not cleared.");
	AST_PDOWN: assert property (pdown && op_end && next_op != OP_PREL |-> !op_take)
		else $error("Command taken in power-down.");
	AST_BUSY: assert property (busy && op_end && next_op == OP_WREN |-> !op_take)
		else $error("Command taken while busy.");
	AST_LOCKED: assert property (addr_end && is_write(op) && blocked |=> !cmd.valid)
		else $error("Write to protected region issued.");
	AST_DESELECT: assert property (cs_s |=> phase == PH_OP && cnt == 5'h00)
		else $error("Deselect did not clear frame.");
	COV_4W: cover property (op_take && next_op == OP_ENTER_4W);
	COV_PAUSE: cover property ($rose(paused));
	COV_DTR_DATA: cover property (out_edge && dtr && data_on);
	COV_SW_RESET: cover property (sw_fire);
endmodule
`default_nettype wire

// >>> tb/sfm_host.sv
// Host controller model driving chip select, serial clock and data lanes.
`default_nettype none
module sfm_host
	import sfm_pkg::*;
(
	output var logic cs_b,
	output var logic sck,
	output wire logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_b
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] hv;
	assign io_in = (io_out & ~io_oe_b) | (hv & io_oe_b);
	initial begin
		cs_b = 1'b1;
		sck = 1'b0;
		hv = 4'hF;
	end
	task automatic clk1(input logic [3:0] v);
		hv = v;
		#100 sck = 1'b1;
		#100 sck = 1'b0;
	endtask
	task automatic sel();
		cs_b = 1'b0;
		#100;
	endtask
	task automatic op(input logic [7:0] o, input logic fw);
		sel();
		if (fw) begin
			clk1(o[7:4]);
			clk1(o[3:0]);
		end else begin
			for (int i = 7; i >= 0; i--) clk1({hv[3], 1'b1, ~hv[1], o[i]});
		end
	endtask
	task automatic addr(input logic [23:0] a);
		for (int i = 23; i >= 0; i--) clk1({hv[3], 1'b1, ~hv[1], a[i]});
	endtask
	task automatic rd(output logic [7:0] b);
		hv[0] = ~hv[0];
		for (int i = 7; i >= 0; i--) begin
			#100 sck = 1'b1;
			#100 b[i] = io_in[1];
			sck = 1'b0;
		end
	endtask
	task automatic fin();
		#100 cs_b = 1'b1;
		hv[2:0] = 3'h7;
		#300;
	endtask
	task automatic pause_pin(input logic v);
		hv[3] = v;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the serial flash mode front end.
`default_nettype none
module tb_top
	import sfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic reset_pin_b = 1'b1;
	logic supply_ok = 1'b1;
	logic busy = 1'b0;
	logic op_done = 1'b0;
	logic range_hit = 1'b0;
	logic [7:0] rd_data = 8'h00;
	sfm_cfg_t cfg = '0;
	wire logic cs_b, sck;
	wire logic [3:0] io_in;
	logic [3:0] io_out, io_oe_b;
	logic rd_next, abort;
	logic [23:0] prot_addr;
	sfm_cmd_t cmd;
	sfm_stat_t stat;
	logic [32:0] exp_q[$];
	logic [31:0] lfsr = 32'h80C8897C;
	logic [7:0] b;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_rd = 0;
	int cyc = 0;
	sfm_front #(.HAS_RESET_PIN(1'b1), .PUW_CYCLES(200)) sfm_front_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.cs_b(cs_b), .sck(sck), .io_in(io_in), .io_out(io_out), .io_oe_b(io_oe_b), .reset_pin_b(reset_pin_b),
		.supply_ok(supply_ok), .cfg(cfg), .busy(busy), .op_done(op_done), .range_hit(range_hit),
		.rd_data(rd_data), .rd_next(rd_next), .prot_addr(prot_addr), .cmd(cmd), .abort(abort), .stat(stat));
	sfm_host sfm_host_i (.cs_b(cs_b), .sck(sck), .io_in(io_in), .io_out(io_out), .io_oe_b(io_oe_b));
	always #12.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic stop_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t read byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cmd(input logic [32:0] e);
		n_compared++;
		if (cmd.opcode !== e[31:24] || (e[32] && cmd.addr !== e[23:0])) begin
			n_mismatch++;
			$display("[FAIL] %0t command %h %h expected %h", $time, cmd.opcode, cmd.addr, e[31:0]);
		end
	endtask
	always @(negedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			stop_test();
		end
		if (rd_next === 1'b1) n_rd++;
		if (cmd.valid === 1'b1 && exp_q.size() > 0) chk_cmd(exp_q.pop_front());
		else if (cmd.valid === 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t unexpected command %h", $time, cmd.opcode);
		end
	end
	task automatic cy(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task automatic fr(input logic [7:0] o, input logic fw, input logic acc);
		if (acc) exp_q.push_back({1'b0, o, 24'h000000});
		sfm_host_i.op(o, fw);
		sfm_host_i.fin();
		cy(1);
	endtask
	task automatic fa(input logic [7:0] o, input logic [23:0] a, input logic acc);
		if (acc) exp_q.push_back({1'b1, o, a});
		sfm_host_i.op(o, 1'b0);
		sfm_host_i.addr(a);
		sfm_host_i.fin();
		cy(1);
	endtask
	initial begin
		cy(20);
		rst_b = 1'b1;
		cy(4);
		chk(stat.write_lockout, 1'b1);
		fr(OP_WREN, 1'b0, 1'b0);
		chk(stat.write_latch_flag, 1'b0);
		cy(200);
		chk(stat.four_wire_command_mode, 1'b0);
		fr(OP_WREN, 1'b0, 1'b1);
		chk(stat.write_latch_flag, 1'b1);
		op_done = 1'b1;
		cy(1);
		op_done = 1'b0;
		cy(3);
		chk(stat.write_latch_flag, 1'b0);
		busy = 1'b1;
		fr(OP_WREN, 1'b0, 1'b0);
		chk(stat.write_latch_flag, 1'b0);
		busy = 1'b0;
		fr(OP_PDOWN, 1'b0, 1'b1);
		fr(OP_WREN, 1'b0, 1'b0);
		chk(stat.power_down, 1'b1);
		chk(stat.write_latch_flag, 1'b0);
		fr(OP_PREL, 1'b0, 1'b1);
		fr(OP_WREN, 1'b0, 1'b1);
		chk(stat.write_latch_flag, 1'b1);
		lfsr = nxt(lfsr);
		rd_data = lfsr[7:0];
		exp_q.push_back({1'b1, OP_READ, lfsr[31:8]});
		sfm_host_i.op(OP_READ, 1'b0);
		sfm_host_i.addr(lfsr[31:8]);
		sfm_host_i.rd(b);
		sfm_host_i.fin();
		cy(1);
		chk_byte(b, lfsr[7:0]);
		chk(n_rd == 2, 1'b1);
		fr(OP_ENTER_4W, 1'b0, 1'b0);
		chk(stat.four_wire_command_mode, 1'b0);
		cfg.quad_enable_bit = 1'b1;
		fr(OP_ENTER_4W, 1'b0, 1'b1);
		chk(stat.four_wire_command_mode, 1'b1);
		fr(OP_WRDI, 1'b1, 1'b1);
		chk(stat.write_latch_flag, 1'b0);
		fr(OP_EXIT_4W, 1'b1, 1'b1);
		chk(stat.four_wire_command_mode, 1'b0);
		fr(OP_ENTER_4W, 1'b0, 1'b1);
		fr(OP_WREN, 1'b1, 1'b1);
		fr(OP_RST_EN, 1'b1, 1'b1);
		fr(OP_RST, 1'b1, 1'b1);
		chk(stat.reset_busy, 1'b1);
		chk(stat.four_wire_command_mode, 1'b0);
		chk(stat.write_latch_flag, 1'b0);
		fr(OP_WREN, 1'b0, 1'b0);
		cy(1250);
		chk(stat.reset_busy, 1'b0);
		chk(stat.write_latch_flag, 1'b0);
		cfg = '0;
		for (int q = 0; q < 2; q++) begin
			cfg.quad_enable_bit = q[0];
			sfm_host_i.sel();
			sfm_host_i.pause_pin(1'b0);
			cy(10);
			chk(stat.paused, ~q[0]);
			sfm_host_i.pause_pin(1'b1);
			cy(10);
			chk(stat.paused, 1'b0);
			sfm_host_i.fin();
			cy(1);
		end
		for (int k = 0; k < 3; k++) begin
			cfg = {k == 0, k == 1, 1'b0};
			cy(300);
			fr(OP_WREN, 1'b0, 1'b1);
			chk(stat.write_latch_flag, 1'b1);
			reset_pin_b = (k != 0);
			if (k == 1) sfm_host_i.pause_pin(1'b0);
			supply_ok = (k != 2);
			fr(OP_WRDI, 1'b0, 1'b0);
			chk(abort, 1'b1);
			chk(stat.reset_busy, 1'b1);
			reset_pin_b = 1'b1;
			sfm_host_i.pause_pin(1'b1);
			supply_ok = 1'b1;
			cy(5);
			chk(stat.write_latch_flag, 1'b0);
		end
		cy(300);
		for (int p = 0; p < 4; p++) begin
			lfsr = nxt(lfsr);
			cfg = {2'b00, p[1]};
			range_hit = p[1] ? lfsr[0] : p[0];
			fr(OP_WREN, 1'b0, 1'b1);
			if (p == 3) fa(OP_UNLOCK, lfsr[31:8], 1'b1);
			fa(OP_PROG, lfsr[31:8], p[1] ? p == 3 : !p[0]);
		end
		range_hit = 1'b0;
		cy(10);
		chk(exp_q.size() == 0, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
